/* File: common/iusc_pkg.sv */
// Package: constants for the infrared status and control block
package iusc_pkg;
   // Register offsets within a bank (byte addresses are four times these)
   localparam logic [2:0] REG_DIV_LOW = 3'h0;
   localparam logic [2:0] REG_DIV_HIGH = 3'h1;
   localparam logic [2:0] REG_CTRL_ONE = 3'h2;
   localparam logic [2:0] REG_BANK_SEL = 3'h3;
   localparam logic [2:0] REG_HANDSHAKE = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   localparam logic [2:0] REG_USER = 3'h7;
   // Bank select codes
   localparam logic [7:0] BANK2_CODE = 8'he0;
   localparam logic [7:0] BANK4_CODE = 8'he8;
   localparam logic [7:0] BANK_SEL_RESET = 8'h00;
   // Advanced control one fields
   localparam int CT1_ADV_SEL = 0;
   localparam int CT1_DMA_SWAP = 3;
   localparam int CT1_ALL_LOOP = 4;
   localparam int CT1_LOOP_OUT = 5;
   localparam int CT1_BAUD_TEST = 7;
   localparam logic [7:0] CT1_RESET = 8'h00;
   localparam logic [7:0] CT1_ADV_CLEAR = 8'ha1;
   localparam logic [7:0] CT1_LEG_CLEAR = 8'ha0;
   // Advanced control two: fall-back disable
   localparam int CT2_FB_DIS = 7;
   // Bank 4 register 3 bits cleared on fall-back
   localparam logic [7:0] B4R3_CLEAR = 8'h0c;
   localparam logic [2:0] REG_B4_R3 = 3'h3;
   // Handshake control mode field
   localparam int HS_MODE_LSB = 5;
   localparam logic [7:0] HS_MODE_MASK = 8'he0;
   localparam logic [7:0] HS_RESET = 8'h60;
   // Status bit positions
   localparam int ST_CRC = 2;
   localparam int ST_SYM = 3;
   localparam int ST_LEN = 4;
   localparam int ST_FEND = 7;
   localparam int US_TOUT = 0;
   localparam int US_FPRES = 1;
   localparam int US_SWFE = 3;
   localparam int US_LOST = 4;
   localparam int US_BUSY = 5;
   localparam int US_UNDR = 6;
   localparam int US_FLOW = 7;
   // Advanced modes
   localparam logic [2:0] MODE_MIR_LO = 3'h1;
   localparam logic [2:0] MODE_MIR_HI = 3'h4;
   localparam logic [2:0] MODE_FIR = 3'h5;
   localparam logic [2:0] MODE_REMOTE = 3'h6;
   localparam logic [7:0] ZERO8 = 8'h00;
   typedef enum logic [1:0] {DMA_NONE, DMA_SINGLE, DMA_DUAL} iusc_dma_type;
endpackage

/* File: core/iusc_core.sv */
// Infrared serial status and control registers behind an APB slave
//
// Overview of operation
// - Receive DMA alone with transmit DMA off means one shared channel.
// - Single channel goes to receiver when swap bit 3 is 0, else transmitter.
// - Frame-end status bit 7 rises when last frame byte reaches FIFO bottom.
// - Oversize frame sets length bit 4 and blocks further FIFO writes.
// - Illegal symbol sets bit 3, aborts decoder and raises frame end.
// - Bad frame checksum in medium or fast mode sets bit 2.
// - Flow control sets bit 7; any read of its register clears it.
// - Empty transmitter without frame end sets underrun; writing 1 clears.
// - Bit 5 shows receiver busy in medium, fast and remote modes.
// - Bit 4 latches lost frame end or remote pulse; read clears it.
// - Bit 1 reads 1 while any frame end remains in receive FIFO.
// - Receive or frame status FIFO timeout sets bit 0.
// - Legacy user register at offset 7 is a plain scratch byte.
// - Legacy latch access in advanced mode forces fall-back, clearing bits.
// - Legacy mode latch access with fall-back on clears bits 5 and 7.
// - Fall-back disabled in legacy mode leaves legacy registers unchanged.
// - Bank 1 offsets 2 to 7 decode as bank 0.
// - Baud test bit drives baud clock onto terminal-ready output.
// - Loopback-output bit keeps transmit data on the infrared pin in loopback.
// - All-mode loopback bit enables loopback in every mode.
// - Writing 1 to advanced-select enters advanced mode.
// - Fall-back-disable bit stops reverting to legacy mode.
// - Fall-back zeroes the mode field and returns to legacy mode.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module iusc_core #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic i_rx_frame_end_bottom,
   input wire logic i_rx_len_over,
   input wire logic i_rx_bad_symbol,
   input wire logic i_rx_crc_bad,
   input wire logic i_flow_event,
   input wire logic i_tx_empty,
   input wire logic i_tx_dma_tc,
   input wire logic i_rx_busy,
   input wire logic i_lost_frame_end,
   input wire logic i_remote_pulse,
   input wire logic i_frame_ends_held,
   input wire logic i_rx_timeout,
   input wire logic i_rx_dma_cfg,
   input wire logic i_tx_dma_cfg,
   input wire logic i_dma_enable,
   input wire logic i_tx_serial,
   input wire logic i_modem_dtr,
   input wire logic i_rx_data_valid,
   output logic o_rx_fifo_write,
   output logic o_decoder_abort,
   output logic o_frame_end,
   output logic o_rx_dma_sel,
   output logic o_tx_dma_sel,
   output logic o_loopback,
   output logic o_infrared_transmit_pin,
   output logic o_terminal_ready,
   output logic [DIV_WIDTH-1:0] o_divisor,
   output logic o_advanced
);
   // Divisor is built from two byte latches only
   if (DIV_WIDTH != 16) begin : g_bad_width
      $error("DIV_WIDTH must be 16");
   end

   logic [7:0] bank_q;
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic [7:0] hs_q;
   logic [7:0] b4r3_q;
   logic [7:0] user_q;
   logic [7:0] div_lo_q;
   logic [7:0] div_hi_q;
   logic [7:0] status_q;
   logic [7:0] ustat_q;
   logic len_block_q;
   logic [DIV_WIDTH-1:0] baud_cnt_q;
   logic baud_clk_q;
   localparam int HS_MODE_LSB = iusc_pkg::HS_MODE_LSB;
   localparam int ST_FEND = iusc_pkg::ST_FEND;
   localparam int ST_LEN = iusc_pkg::ST_LEN;
   localparam int ST_SYM = iusc_pkg::ST_SYM;
   localparam int ST_CRC = iusc_pkg::ST_CRC;

   // Bank number from selector value
   function automatic logic [2:0] bank_of(input logic [7:0] sel);
      logic [2:0] b;
      b = 3'h1;
      if (!sel[7]) begin
         b = 3'h0;
      end else if (sel == iusc_pkg::BANK2_CODE) begin
         b = 3'h2;
      end else if (sel == iusc_pkg::BANK4_CODE) begin
         b = 3'h4;
      end else if (sel[7:5] == 3'h7 && sel[1:0] == 2'h0) begin
         b = 3'h7;
      end
      return b;
   endfunction

   logic [2:0] bank;
   logic [2:0] off;
   logic acc;
   logic wr;
   logic rd;
   logic legacy_bank;
   logic latch_acc;
   logic adv_mode;
   logic fast_mode;
   logic remote_mode;
   logic fallback_adv;
   logic fallback_leg;
   logic [2:0] mode;
   logic [7:0] wd;
   logic underrun_ev;

   assign bank = bank_of(bank_q);
   // Bank 1 upper offsets mirror bank 0
   assign legacy_bank = (bank == 3'h0) || (bank == 3'h1);
   assign off = paddr[4:2];
   assign wd = pwdata[7:0];
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign mode = hs_q[HS_MODE_LSB+2:HS_MODE_LSB];
   assign adv_mode = ctrl1_q[iusc_pkg::CT1_ADV_SEL];
   assign fast_mode = adv_mode && (mode == iusc_pkg::MODE_MIR_LO ||
      mode == iusc_pkg::MODE_MIR_HI || mode == iusc_pkg::MODE_FIR);
   assign remote_mode = adv_mode && (mode == iusc_pkg::MODE_REMOTE);
   assign latch_acc = acc && (bank == 3'h1) &&
      (off == iusc_pkg::REG_DIV_LOW || off == iusc_pkg::REG_DIV_HIGH);
   // Fall-back disable blocks every fall-back effect
   assign fallback_adv = latch_acc && adv_mode &&
      !ctrl2_q[iusc_pkg::CT2_FB_DIS];
   assign fallback_leg = latch_acc && !adv_mode &&
      !ctrl2_q[iusc_pkg::CT2_FB_DIS];

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bank_q <= iusc_pkg::BANK_SEL_RESET;
      end else if (wr && off == iusc_pkg::REG_BANK_SEL) begin
         bank_q <= wd;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl1_q <= iusc_pkg::CT1_RESET;
      end else if (fallback_adv) begin
         ctrl1_q <= ctrl1_q & ~iusc_pkg::CT1_ADV_CLEAR;
      end else if (fallback_leg) begin
         ctrl1_q <= ctrl1_q & ~iusc_pkg::CT1_LEG_CLEAR;
      end else if (wr && bank == 3'h2 && off == iusc_pkg::REG_CTRL_ONE) begin
         ctrl1_q <= wd;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl2_q <= iusc_pkg::ZERO8;
      end else if (wr && bank == 3'h2 && off == iusc_pkg::REG_HANDSHAKE) begin
         ctrl2_q <= wd;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hs_q <= iusc_pkg::HS_RESET;
      end else if (fallback_adv) begin
         hs_q <= hs_q & ~iusc_pkg::HS_MODE_MASK;
      end else if (wr && legacy_bank && off == iusc_pkg::REG_HANDSHAKE) begin
         hs_q <= wd;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         b4r3_q <= iusc_pkg::ZERO8;
      end else if (fallback_adv) begin
         b4r3_q <= b4r3_q & ~iusc_pkg::B4R3_CLEAR;
      end else if (wr && bank == 3'h4 && off == iusc_pkg::REG_B4_R3) begin
         b4r3_q <= wd;
      end
   end

   // Either latch bank writes the same divisor
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_lo_q <= iusc_pkg::ZERO8;
         div_hi_q <= iusc_pkg::ZERO8;
      end else if (wr && (bank == 3'h1 || bank == 3'h2)) begin
         if (off == iusc_pkg::REG_DIV_LOW) begin
            div_lo_q <= wd;
         end
         if (off == iusc_pkg::REG_DIV_HIGH) begin
            div_hi_q <= wd;
         end
      end
   end

   logic user_wr;
   logic user_rd;
   assign user_wr = wr && legacy_bank && off == iusc_pkg::REG_USER;
   assign user_rd = rd && legacy_bank && off == iusc_pkg::REG_USER;

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         user_q <= iusc_pkg::ZERO8;
      end else if (user_wr && !adv_mode) begin
         user_q <= wd;
      end
   end

   // Frame status flags follow events; length flag clears when overflow and data valid are both low
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= iusc_pkg::ZERO8;
         len_block_q <= 1'b0;
      end else begin
         status_q[ST_FEND] <= fast_mode && i_rx_frame_end_bottom;
         if (fast_mode && i_rx_len_over) begin
            status_q[ST_LEN] <= 1'b1;
            len_block_q <= 1'b1;
         end else if (!i_rx_data_valid && !i_rx_len_over) begin
            len_block_q <= 1'b0;
            status_q[ST_LEN] <= 1'b0;
         end
         status_q[ST_SYM] <= fast_mode && i_rx_bad_symbol;
         status_q[ST_CRC] <= fast_mode && i_rx_crc_bad;
      end
   end
   assign o_rx_fifo_write = i_rx_data_valid && !len_block_q;
   assign o_decoder_abort = status_q[ST_SYM];
   assign o_frame_end = status_q[ST_SYM] || status_q[ST_FEND];

   assign underrun_ev = fast_mode && i_tx_empty &&
      (i_dma_enable ? !i_tx_dma_tc : !ustat_q[iusc_pkg::US_SWFE]);

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ustat_q <= iusc_pkg::ZERO8;
      end else begin
         if (i_flow_event) begin
            ustat_q[iusc_pkg::US_FLOW] <= 1'b1;
         end else if (user_rd) begin
            ustat_q[iusc_pkg::US_FLOW] <= 1'b0;
         end
         if (underrun_ev) begin
            ustat_q[iusc_pkg::US_UNDR] <= 1'b1;
         end else if (user_wr && wd[iusc_pkg::US_UNDR]) begin
            ustat_q[iusc_pkg::US_UNDR] <= 1'b0;
         end
         ustat_q[iusc_pkg::US_BUSY] <= (fast_mode || remote_mode) &&
            i_rx_busy;
         if ((fast_mode && i_lost_frame_end) ||
             (remote_mode && i_remote_pulse)) begin
            ustat_q[iusc_pkg::US_LOST] <= 1'b1;
         end else if (user_rd) begin
            ustat_q[iusc_pkg::US_LOST] <= 1'b0;
         end
         if (user_wr && adv_mode) begin
            ustat_q[iusc_pkg::US_SWFE] <= wd[iusc_pkg::US_SWFE];
         end
         ustat_q[iusc_pkg::US_FPRES] <= i_frame_ends_held;
         ustat_q[iusc_pkg::US_TOUT] <= (fast_mode || remote_mode) &&
            i_rx_timeout;
      end
   end

   // DMA channel routing
   iusc_pkg::iusc_dma_type dma_cfg;
   always_comb begin
      dma_cfg = iusc_pkg::DMA_NONE;
      if (i_dma_enable && i_rx_dma_cfg && !i_tx_dma_cfg) begin
         dma_cfg = iusc_pkg::DMA_SINGLE;
      end else if (i_dma_enable && i_rx_dma_cfg) begin
         dma_cfg = iusc_pkg::DMA_DUAL;
      end
   end

   always_comb begin
      o_rx_dma_sel = 1'b0;
      o_tx_dma_sel = 1'b0;
      unique case (dma_cfg)
         iusc_pkg::DMA_NONE: begin
         end
         iusc_pkg::DMA_SINGLE: begin
            o_rx_dma_sel = !ctrl1_q[iusc_pkg::CT1_DMA_SWAP];
            o_tx_dma_sel = ctrl1_q[iusc_pkg::CT1_DMA_SWAP];
         end
         iusc_pkg::DMA_DUAL: begin
            o_rx_dma_sel = 1'b1;
            o_tx_dma_sel = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Baud clock for divisor test; divisor 0 holds the clock still
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         baud_cnt_q <= '0;
         baud_clk_q <= 1'b0;
      end else if (o_divisor == '0) begin
         baud_cnt_q <= '0;
      end else if (baud_cnt_q >= o_divisor - DIV_WIDTH'(1)) begin
         baud_cnt_q <= '0;
         baud_clk_q <= !baud_clk_q;
      end else begin
         baud_cnt_q <= baud_cnt_q + DIV_WIDTH'(1);
      end
   end

   assign o_divisor = {div_hi_q, div_lo_q};
   assign o_advanced = adv_mode;
   assign o_terminal_ready = ctrl1_q[iusc_pkg::CT1_BAUD_TEST] ?
      baud_clk_q : i_modem_dtr;
   assign o_loopback = ctrl1_q[iusc_pkg::CT1_ALL_LOOP] ||
      (!adv_mode && hs_q[iusc_pkg::CT1_ALL_LOOP]);
   // Loopback normally parks the infrared pin low
   assign o_infrared_transmit_pin = (!o_loopback ||
      ctrl1_q[iusc_pkg::CT1_LOOP_OUT]) ? i_tx_serial : 1'b0;

   // Read mux
   logic [7:0] rmux;
   always_comb begin
      rmux = iusc_pkg::ZERO8;
      if (bank == 3'h1 && off == iusc_pkg::REG_DIV_LOW) begin
         rmux = div_lo_q;
      end else if (bank == 3'h1 && off == iusc_pkg::REG_DIV_HIGH) begin
         rmux = div_hi_q;
      end else if (bank == 3'h2 && off == iusc_pkg::REG_DIV_LOW) begin
         rmux = div_lo_q;
      end else if (bank == 3'h2 && off == iusc_pkg::REG_DIV_HIGH) begin
         rmux = div_hi_q;
      end else if (bank == 3'h2 && off == iusc_pkg::REG_CTRL_ONE) begin
         rmux = ctrl1_q;
      end else if (bank == 3'h2 && off == iusc_pkg::REG_HANDSHAKE) begin
         rmux = ctrl2_q;
      end else if (off == iusc_pkg::REG_BANK_SEL) begin
         rmux = bank_q;
      end else if (bank == 3'h4 && off == iusc_pkg::REG_B4_R3) begin
         rmux = b4r3_q;
      end else if (legacy_bank && off == iusc_pkg::REG_HANDSHAKE) begin
         rmux = hs_q;
      end else if (legacy_bank && off == iusc_pkg::REG_STATUS) begin
         rmux = status_q;
      end else if (legacy_bank && off == iusc_pkg::REG_USER) begin
         rmux = adv_mode ? ustat_q : user_q;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {24'h000000, rmux};
      end
   end

   sequence fb_cause_s;
      fallback_adv;
   endsequence
   sequence fb_effect_s;
      !ctrl1_q[iusc_pkg::CT1_ADV_SEL] && hs_q[7:5] == 3'h0;
   endsequence

   fallback_clear_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) fb_cause_s |=> fb_effect_s)
      else $error("fall-back did not clear mode bits");
   fallback_legacy_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) fallback_leg |=>
      !ctrl1_q[7] && !ctrl1_q[5] && ctrl1_q[0] == $past(ctrl1_q[0]))
      else $error("legacy fall-back cleared wrong bits");
   fallback_off_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) latch_acc && ctrl2_q[7] |=>
      $stable(ctrl1_q) && $stable(hs_q))
      else $error("fall-back happened while disabled");
   flow_read_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) user_rd && !i_flow_event |=> !ustat_q[7])
      else $error("flow flag not cleared by read");
   flow_set_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) i_flow_event |=> ustat_q[7])
      else $error("flow flag not set");
   underrun_set_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) underrun_ev |=> ustat_q[6])
      else $error("underrun not set");
   len_block_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) fast_mode && i_rx_len_over |=> !o_rx_fifo_write)
      else $error("data written after length exceeded");
   dma_swap_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) dma_cfg == iusc_pkg::DMA_SINGLE |->
      o_tx_dma_sel == ctrl1_q[3] && o_rx_dma_sel != o_tx_dma_sel)
      else $error("single channel routed wrongly");
   baud_test_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) ctrl1_q[7] |-> o_terminal_ready == baud_clk_q)
      else $error("baud clock not on terminal ready");
   lost_read_a: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) user_rd && !i_lost_frame_end && !i_remote_pulse
      |=> !ustat_q[4])
      else $error("lost frame flag not read-cleared");
endmodule
`default_nettype wire

/* File: dv/iusc_xcvr_model.sv */
// Infrared transceiver stand-in driving receive and transmit events
`timescale 1ns/1ps
`default_nettype none
module iusc_xcvr_model (
   input wire logic i_ref_clk,
   output logic o_rx_frame_end_bottom,
   output logic o_rx_len_over,
   output logic o_rx_bad_symbol,
   output logic o_rx_crc_bad,
   output logic o_flow_event,
   output logic o_tx_empty,
   output logic o_tx_dma_tc,
   output logic o_rx_busy,
   output logic o_lost_frame_end,
   output logic o_remote_pulse,
   output logic o_frame_ends_held,
   output logic o_rx_timeout,
   output logic o_tx_serial,
   output logic o_modem_dtr,
   output logic o_rx_data_valid
);
   // Bit order matches the bench event masks, msb first
   logic [14:0] line_q = 15'h0000;
   assign {o_rx_frame_end_bottom, o_rx_len_over, o_rx_bad_symbol,
      o_rx_crc_bad, o_flow_event, o_tx_empty, o_tx_dma_tc, o_rx_busy,
      o_lost_frame_end, o_remote_pulse, o_frame_ends_held, o_rx_timeout,
      o_tx_serial, o_modem_dtr, o_rx_data_valid} = line_q;
   // Lines move only just after a rising edge
   task automatic drive(input logic [14:0] v);
      @(posedge i_ref_clk);
      line_q <= v;
   endtask
   // One-cycle event, all lines idle afterwards
   task automatic pulse(input logic [14:0] v);
      drive(v);
      drive(15'h0000);
   endtask
endmodule
`default_nettype wire

/* File: dv/test_infrared_uart_status_control.sv */
// Self-checking bench for the infrared status and control block
`timescale 1ns/1ps
`default_nettype none
module test_infrared_uart_status_control;
   localparam logic [14:0] X_FEB = 15'h4000, X_LEN = 15'h2000,
      X_SYM = 15'h1000, X_CRC = 15'h0800, X_FLOW = 15'h0400,
      X_TXE = 15'h0200, X_BUSY = 15'h0080, X_LOST = 15'h0040,
      X_RPUL = 15'h0020, X_HELD = 15'h0010, X_TOUT = 15'h0008,
      X_TXS = 15'h0004, X_DTR = 15'h0002, X_DV = 15'h0001;
   localparam logic [7:0] B2 = iusc_pkg::BANK2_CODE;
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0, prev;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic pready, pslverr;
   logic i_dma_enable = 1'b0, i_rx_dma_cfg = 1'b0, i_tx_dma_cfg = 1'b0;
   logic i_rx_frame_end_bottom, i_rx_len_over, i_rx_bad_symbol;
   logic i_rx_crc_bad, i_flow_event, i_tx_empty, i_tx_dma_tc, i_rx_busy;
   logic i_lost_frame_end, i_remote_pulse, i_frame_ends_held, i_rx_timeout;
   logic i_tx_serial, i_modem_dtr, i_rx_data_valid;
   logic o_rx_fifo_write, o_decoder_abort, o_frame_end, o_rx_dma_sel;
   logic o_tx_dma_sel, o_loopback, o_infrared_transmit_pin;
   logic o_terminal_ready, o_advanced;
   logic [15:0] o_divisor;
   int mismatches = 0;
   int check_count = 0;
   int toggles = 0;

   iusc_core #(.DIV_WIDTH(16)) u_iusc_core (
      .i_ref_clk, .i_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .i_rx_frame_end_bottom, .i_rx_len_over,
      .i_rx_bad_symbol, .i_rx_crc_bad, .i_flow_event, .i_tx_empty,
      .i_tx_dma_tc, .i_rx_busy, .i_lost_frame_end, .i_remote_pulse,
      .i_frame_ends_held, .i_rx_timeout, .i_rx_dma_cfg, .i_tx_dma_cfg,
      .i_dma_enable, .i_tx_serial, .i_modem_dtr, .i_rx_data_valid,
      .o_rx_fifo_write, .o_decoder_abort, .o_frame_end, .o_rx_dma_sel,
      .o_tx_dma_sel, .o_loopback, .o_infrared_transmit_pin,
      .o_terminal_ready, .o_divisor, .o_advanced);
   iusc_xcvr_model u_iusc_xcvr_model (.i_ref_clk,
      .o_rx_frame_end_bottom(i_rx_frame_end_bottom),
      .o_rx_len_over(i_rx_len_over), .o_rx_bad_symbol(i_rx_bad_symbol),
      .o_rx_crc_bad(i_rx_crc_bad), .o_flow_event(i_flow_event),
      .o_tx_empty(i_tx_empty), .o_tx_dma_tc(i_tx_dma_tc),
      .o_rx_busy(i_rx_busy), .o_lost_frame_end(i_lost_frame_end),
      .o_remote_pulse(i_remote_pulse),
      .o_frame_ends_held(i_frame_ends_held), .o_rx_timeout(i_rx_timeout),
      .o_tx_serial(i_tx_serial), .o_modem_dtr(i_modem_dtr),
      .o_rx_data_valid(i_rx_data_valid));

   always #2.5 i_ref_clk = ~i_ref_clk;

   task automatic close_out;
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask

   task automatic bit_chk(input logic got, exp, input string what);
      cmp({31'h0, got}, {31'h0, exp}, what);
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb_xfer(input logic wr, input logic [2:0] idx,
      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {3'h0, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge i_ref_clk);
      penable <= 1'b1;
      @(posedge i_ref_clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge i_ref_clk);
         n++;
      end
      rdata = prdata;
      cmp({31'h0, pslverr}, 32'h0, "slave error");
      cmp(n, 0, "pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      apb_xfer(1'b1, idx, d);
   endtask

   task automatic chk(input logic [2:0] idx, input logic [7:0] exp);
      apb_xfer(1'b0, idx, 8'h00);
      cmp(rdata, {24'h0, exp}, "register read");
   endtask

   task automatic bank(input logic [7:0] code);
      wr(iusc_pkg::REG_BANK_SEL, code);
   endtask

   task automatic ev(input logic [14:0] v);
      u_iusc_xcvr_model.drive(v);
   endtask

   task automatic settle;
      @(negedge i_ref_clk);
   endtask

   // Whole sequence needs well under a thousand cycles
   initial begin
      #50000;
      mismatches++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      chk(3'h5, 8'h00);
      chk(3'h7, 8'h00);
      wr(3'h7, 8'ha5);
      chk(3'h7, 8'ha5);
      bank(8'h80);
      chk(3'h7, 8'ha5);
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      settle();
      cmp({16'h0, o_divisor}, 32'h1234, "divisor");
      bank(B2);
      chk(3'h2, 8'h00);
      wr(3'h5, 8'hff);
      chk(3'h5, 8'h00);
      wr(3'h2, 8'ha8);
      bank(8'h80);
      wr(3'h0, 8'h34);
      bank(B2);
      chk(3'h2, 8'h08);
      wr(3'h2, 8'h01);
      settle();
      bit_chk(o_advanced, 1'b1, "advanced");
      bank(8'h00);
      wr(3'h4, 8'ha0);
      bank(B2);
      @(posedge i_ref_clk);
      i_dma_enable <= 1'b1;
      i_rx_dma_cfg <= 1'b1;
      settle();
      bit_chk(o_rx_dma_sel, 1'b1, "rx dma");
      bit_chk(o_tx_dma_sel, 1'b0, "tx dma");
      wr(3'h2, 8'h09);
      settle();
      bit_chk(o_tx_dma_sel, 1'b1, "tx dma");
      bit_chk(o_rx_dma_sel, 1'b0, "rx dma");
      wr(3'h2, 8'h31);
      i_tx_dma_cfg <= 1'b1;
      settle();
      bit_chk(o_rx_dma_sel & o_tx_dma_sel, 1'b1, "dual dma");
      bit_chk(o_loopback, 1'b1, "loopback");
      ev(X_TXS);
      // Programmed I/O from here, so frame end gates underrun
      i_dma_enable <= 1'b0;
      settle();
      bit_chk(o_infrared_transmit_pin, 1'b1, "ir pin");
      wr(3'h2, 8'h11);
      ev(X_DTR | X_TXS);
      settle();
      bit_chk(o_infrared_transmit_pin, 1'b0, "ir pin");
      bit_chk(o_terminal_ready, 1'b1, "terminal ready");
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h00);
      wr(3'h2, 8'h81);
      settle();
      bit_chk(o_advanced, 1'b1, "advanced");
      prev = o_terminal_ready;
      repeat (200) begin
         @(negedge i_ref_clk);
         if (o_terminal_ready !== prev)
            toggles++;
         prev = o_terminal_ready;
      end
      bit_chk(toggles >= 2, 1'b1, "baud clock");
      ev(15'h0000);
      wr(3'h2, 8'h01);
      bank(8'h00);
      ev(X_SYM);
      chk(3'h5, 8'h08);
      settle();
      bit_chk(o_decoder_abort, 1'b1, "abort");
      bit_chk(o_frame_end, 1'b1, "frame end");
      ev(X_CRC | X_LEN | X_FEB | X_DV);
      chk(3'h5, 8'h94);
      settle();
      bit_chk(o_rx_fifo_write, 1'b0, "fifo write");
      ev(15'h0000);
      chk(3'h5, 8'h00);
      ev(X_DV);
      settle();
      bit_chk(o_rx_fifo_write, 1'b1, "fifo write");
      ev(X_BUSY | X_HELD | X_TOUT);
      chk(3'h7, 8'h23);
      u_iusc_xcvr_model.pulse(X_FLOW | X_LOST | X_TXE);
      chk(3'h7, 8'hd0);
      chk(3'h7, 8'h40);
      wr(3'h7, 8'h40);
      chk(3'h7, 8'h00);
      wr(3'h7, 8'h08);
      u_iusc_xcvr_model.pulse(X_TXE);
      chk(3'h7, 8'h08);
      wr(3'h7, 8'h00);
      wr(3'h4, 8'hc0);
      u_iusc_xcvr_model.pulse(X_RPUL);
      chk(3'h7, 8'h10);
      chk(3'h7, 8'h00);
      ev(X_BUSY);
      chk(3'h7, 8'h20);
      ev(15'h0000);
      bank(B2);
      wr(3'h4, 8'h80);
      bank(8'h80);
      wr(3'h0, 8'h05);
      settle();
      bit_chk(o_advanced, 1'b1, "advanced");
      bank(B2);
      wr(3'h4, 8'h00);
      wr(3'h2, 8'hb9);
      bank(8'h00);
      wr(3'h4, 8'ha0);
      bank(8'h80);
      wr(3'h0, 8'h05);
      settle();
      bit_chk(o_advanced, 1'b0, "advanced");
      chk(3'h4, 8'h00);
      bank(B2);
      chk(3'h2, 8'h18);
      close_out();
   end
endmodule
`default_nettype wire
